// File: epc_defines.svh
// register map, field positions and codes of the pin-change interrupt block
// How it works
// R1 - sense code 00 low level, 01 any change, 10 falling, 11 rising edge
// R2 - dedicated pin is sampled first; pulses over one clock always caught
// R3 - in low-level mode the source holds the pin low until taken
// R4 - dedicated pin request needs global enable and its enable bit
// R5 - dedicated pin enable is bit 0; pin activity counts even as output
// R6 - group 3 enable bit 7 passes changes on inputs 30 to 24
// R7 - group 2 enable bit 6 passes changes on inputs 23 to 16
// R8 - group 1 enable bit 5 passes changes on inputs 15 to 8
// R9 - group 0 enable bit 4 passes changes on inputs 7 to 0
// R10 - software writes zero to group 2 and 3 bits on small variants
// R11 - a change in group 3, 2, 1, 0 sets flag bit 7, 6, 5, 4
// R12 - an edge or change on the dedicated pin sets flag bit 0
// R13 - set flag with both enables requests that source's own vector
// R14 - hardware clears a flag when its routine is entered
// R15 - writing one to a flag clears it; writing zero leaves it
// R16 - in low-level mode the dedicated pin flag reads zero
// R17 - mask register 3 bits 6 to 0 enable inputs 30 to 24
// R18 - mask register 2 bits 7 to 0 enable inputs 23 to 16
// R19 - mask register 1 bits 7 to 0 enable inputs 15 to 8
// R20 - mask register 0 at 0x6B enables inputs 7 to 0
// R21 - pin-change detection serves wake-up from clock-stopped sleep
// R22 - low level works without clock; edges need the clock
// R23 - reserved bits read zero and ignore writes; all reset to zero
// R24 - each change input is compared with its last sample every cycle
`ifndef EPC_DEFINES_SVH
`define EPC_DEFINES_SVH

// register indices; byte address is four times the index
`define EPC_IDX_FLAGS 8'h3C
`define EPC_IDX_ENABLES 8'h3D
`define EPC_IDX_SENSE 8'h69
`define EPC_IDX_MASK0 8'h6B
`define EPC_IDX_MASK1 8'h6C
`define EPC_IDX_MASK2 8'h6D
`define EPC_IDX_MASK3 8'h73
`define EPC_ADDR_W 10

// writable bit masks, reserved bits are zero
`define EPC_WMASK_FLAGS 8'hF1
`define EPC_WMASK_ENABLES 8'hF1
`define EPC_WMASK_SENSE 8'h03
`define EPC_WMASK_MASK3 8'h7F
`define EPC_RESET_VAL 8'h00

// field positions
`define EPC_BIT_PIN 0
`define EPC_BIT_GRP0 4

// sense codes
`define EPC_SENSE_LOW 2'h0
`define EPC_SENSE_ANY 2'h1
`define EPC_SENSE_FALL 2'h2
`define EPC_SENSE_RISE 2'h3

`define EPC_NUM_GRP 4
`define EPC_NUM_CHG 31

`endif

// File: epc_pkg.sv
// types of the pin-change interrupt block
package epc_pkg;

  // one bit per interrupt vector
  typedef struct packed {
    logic grp3;
    logic grp2;
    logic grp1;
    logic grp0;
    logic pin;
  } epc_vec_t;

  // latched address phase of an ahb transfer
  typedef struct packed {
    logic [9:0] addr;
    logic write;
    logic mapped;
  } epc_aphase_t;

  // bus access state
  typedef enum logic [1:0] {
    EPC_BUS_IDLE,
    EPC_BUS_WRITE,
    EPC_BUS_RDWAIT
  } epc_bus_t;

endpackage

// File: epc_irq.sv
// external dedicated pin and pin-change interrupt controller with ahb-lite slave
//
// Implementation choice: the AHB-Lite slave port.
`include "epc_defines.svh"

module epc_irq
  import epc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic dedicated_ext_irq_pin,
  input wire logic [30:0] change_inputs,
  input wire logic cpu_global_ie,
  input wire epc_vec_t irq_ack,
  output epc_vec_t irq_req
);

  logic [7:0] ext_irq_flags;
  logic [7:0] ext_irq_enables;
  logic [7:0] ext_irq_sense_control;
  logic [7:0] pin_change_mask_group0;
  logic [7:0] pin_change_mask_group1;
  logic [7:0] pin_change_mask_group2;
  logic [7:0] pin_change_mask_group3;

  logic pin_q;
  logic pin_prev;
  logic [30:0] chg_q;
  logic [30:0] chg_prev;
  logic [31:0] chg_diff;
  logic [31:0] mask_all;
  logic [3:0] grp_hit;
  logic pin_edge;
  logic level_mode;

  epc_bus_t bus_st;
  epc_aphase_t aph;
  logic accept;
  logic [9:0] a_low;
  logic a_mapped;
  logic wr_now;
  logic [7:0] wdat;
  logic [7:0] rmux;
  logic [7:0] set_ev;
  logic [7:0] clr_ev;
  logic [7:0] ack_bits;
  logic [7:0] next_flags;
  epc_vec_t next_req;

  // ---------------- bus slave ----------------
  assign accept = hsel && hready && htrans[1];
  assign a_low = haddr[9:0];
  assign a_mapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0) && (
    a_low == {`EPC_IDX_FLAGS, 2'h0} || a_low == {`EPC_IDX_ENABLES, 2'h0} ||
    a_low == {`EPC_IDX_SENSE, 2'h0} || a_low == {`EPC_IDX_MASK0, 2'h0} ||
    a_low == {`EPC_IDX_MASK1, 2'h0} || a_low == {`EPC_IDX_MASK2, 2'h0} ||
    a_low == {`EPC_IDX_MASK3, 2'h0});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st <= EPC_BUS_IDLE;
      aph <= '0;
    end else begin
      case (bus_st)
        EPC_BUS_RDWAIT: begin
          bus_st <= EPC_BUS_IDLE;
        end
        default: begin
          if (accept) begin
            aph <= '{addr: a_low, write: hwrite, mapped: a_mapped};
            bus_st <= hwrite ? EPC_BUS_WRITE : EPC_BUS_RDWAIT;
          end else begin
            bus_st <= EPC_BUS_IDLE;
          end
        end
      endcase
    end
  end

  // reads take one wait state so the data reflect any write just finished
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(accept && !hwrite && bus_st != EPC_BUS_RDWAIT);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  assign wr_now = (bus_st == EPC_BUS_WRITE) && aph.mapped;
  assign wdat = hwdata[7:0];

  always_comb begin
    rmux = 8'h00;
    if (aph.mapped) begin
      case (aph.addr)
        {`EPC_IDX_FLAGS, 2'h0}: rmux = ext_irq_flags;
        {`EPC_IDX_ENABLES, 2'h0}: rmux = ext_irq_enables;
        {`EPC_IDX_SENSE, 2'h0}: rmux = ext_irq_sense_control;
        {`EPC_IDX_MASK0, 2'h0}: rmux = pin_change_mask_group0;
        {`EPC_IDX_MASK1, 2'h0}: rmux = pin_change_mask_group1;
        {`EPC_IDX_MASK2, 2'h0}: rmux = pin_change_mask_group2;
        {`EPC_IDX_MASK3, 2'h0}: rmux = pin_change_mask_group3;
        default: rmux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (bus_st == EPC_BUS_RDWAIT) begin
      hrdata <= {24'h000000, rmux};
    end
  end

  // ---------------- control registers ----------------
  // R23 reserved bits masked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_irq_enables <= `EPC_RESET_VAL;
      ext_irq_sense_control <= `EPC_RESET_VAL;
    end else if (wr_now) begin
      if (aph.addr == {`EPC_IDX_ENABLES, 2'h0}) begin
        ext_irq_enables <= wdat & `EPC_WMASK_ENABLES;
      end
      if (aph.addr == {`EPC_IDX_SENSE, 2'h0}) begin
        ext_irq_sense_control <= wdat & `EPC_WMASK_SENSE;
      end
    end
  end

  // R17 R18 R19 R20 per-input mask registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_change_mask_group0 <= `EPC_RESET_VAL;
      pin_change_mask_group1 <= `EPC_RESET_VAL;
      pin_change_mask_group2 <= `EPC_RESET_VAL;
      pin_change_mask_group3 <= `EPC_RESET_VAL;
    end else if (wr_now) begin
      if (aph.addr == {`EPC_IDX_MASK0, 2'h0}) begin
        pin_change_mask_group0 <= wdat;
      end
      if (aph.addr == {`EPC_IDX_MASK1, 2'h0}) begin
        pin_change_mask_group1 <= wdat;
      end
      if (aph.addr == {`EPC_IDX_MASK2, 2'h0}) begin
        pin_change_mask_group2 <= wdat;
      end
      if (aph.addr == {`EPC_IDX_MASK3, 2'h0}) begin
        pin_change_mask_group3 <= wdat & `EPC_WMASK_MASK3;
      end
    end
  end

  // ---------------- input sampling ----------------
  // R2 R24 sample then compare with previous sample
  // R21 R22 detection here is clocked; clock-free wake lies outside
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q <= 1'b1;
      pin_prev <= 1'b1;
      chg_q <= 31'h00000000;
      chg_prev <= 31'h00000000;
    end else begin
      pin_q <= dedicated_ext_irq_pin;
      pin_prev <= pin_q;
      chg_q <= change_inputs;
      chg_prev <= chg_q;
    end
  end

  assign level_mode = ext_irq_sense_control[1:0] == `EPC_SENSE_LOW;

  // R1 edge selection by sense code
  always_comb begin
    case (ext_irq_sense_control[1:0])
      `EPC_SENSE_ANY: pin_edge = pin_q != pin_prev;
      `EPC_SENSE_FALL: pin_edge = pin_prev && !pin_q;
      `EPC_SENSE_RISE: pin_edge = !pin_prev && pin_q;
      default: pin_edge = 1'b0;
    endcase
  end

  // R24 difference per input
  assign chg_diff = {1'b0, chg_q ^ chg_prev};
  assign mask_all = {pin_change_mask_group3 & `EPC_WMASK_MASK3, pin_change_mask_group2,
    pin_change_mask_group1, pin_change_mask_group0};

  // R6 R7 R8 R9 group hit from unmasked changes
  genvar g;
  generate
    for (g = 0; g < `EPC_NUM_GRP; g++) begin : gen_grp
      assign grp_hit[g] = |(chg_diff[8*g +: 8] & mask_all[8*g +: 8]);
    end
  endgenerate

  // ---------------- flags ----------------
  // R11 R12 set events aligned with flag bits
  assign set_ev = {grp_hit, 3'h0, pin_edge};
  assign ack_bits = {irq_ack.grp3, irq_ack.grp2, irq_ack.grp1, irq_ack.grp0, 3'h0, irq_ack.pin};
  // R14 R15 ack and write-one clear sources
  assign clr_ev = ack_bits | ((wr_now && aph.addr == {`EPC_IDX_FLAGS, 2'h0}) ?
    (wdat & `EPC_WMASK_FLAGS) : 8'h00);

  always_comb begin
    // set wins over clear
    next_flags = ((ext_irq_flags & ~clr_ev) | set_ev) & `EPC_WMASK_FLAGS;
    // R16 flag held cleared in low-level mode
    if (level_mode) begin
      next_flags[`EPC_BIT_PIN] = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_irq_flags <= `EPC_RESET_VAL;
    end else begin
      ext_irq_flags <= next_flags;
    end
  end

  // ---------------- vector requests ----------------
  // R4 R5 R13 each request gated by global and own enable
  always_comb begin
    next_req.pin = cpu_global_ie && ext_irq_enables[`EPC_BIT_PIN] &&
      (level_mode ? !pin_q : ext_irq_flags[`EPC_BIT_PIN]);
    next_req.grp0 = cpu_global_ie && ext_irq_enables[`EPC_BIT_GRP0] &&
      ext_irq_flags[`EPC_BIT_GRP0];
    next_req.grp1 = cpu_global_ie && ext_irq_enables[`EPC_BIT_GRP0 + 1] &&
      ext_irq_flags[`EPC_BIT_GRP0 + 1];
    next_req.grp2 = cpu_global_ie && ext_irq_enables[`EPC_BIT_GRP0 + 2] &&
      ext_irq_flags[`EPC_BIT_GRP0 + 2];
    next_req.grp3 = cpu_global_ie && ext_irq_enables[`EPC_BIT_GRP0 + 3] &&
      ext_irq_flags[`EPC_BIT_GRP0 + 3];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req <= '0;
    end else begin
      irq_req <= next_req;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read_taken;
    accept && !hwrite && bus_st != EPC_BUS_RDWAIT;
  endsequence

  sequence s_read_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_wait_state: assert property (s_read_taken |=> s_read_answer) // reads answer after exactly one wait state
    else $error("read answer not after exactly one wait state");

  a_level_flag_zero: assert property ( // R16
    $past(level_mode) |-> !ext_irq_flags[`EPC_BIT_PIN])
    else $error("pin flag set in low-level mode");

  a_rise_sets_flag: assert property ( // R1
    (ext_irq_sense_control[1:0] == `EPC_SENSE_RISE && !pin_prev && pin_q)
    |=> ext_irq_flags[`EPC_BIT_PIN])
    else $error("rising edge did not set pin flag");

  a_fall_sets_flag: assert property ( // R12
    (ext_irq_sense_control[1:0] == `EPC_SENSE_FALL && pin_prev && !pin_q)
    |=> ext_irq_flags[`EPC_BIT_PIN])
    else $error("falling edge did not set pin flag");

  a_pulse_caught: assert property ( // R2
    (ext_irq_sense_control[1:0] == `EPC_SENSE_ANY && !ext_irq_flags[0] && !irq_ack.pin
      && dedicated_ext_irq_pin != pin_q) ##1 !irq_ack.pin |=> ext_irq_flags[`EPC_BIT_PIN])
    else $error("pin toggle of one clock not flagged");

  a_grp1_change_flag: assert property ( // R8
    |(chg_diff[15:8] & pin_change_mask_group1) |=> ext_irq_flags[`EPC_BIT_GRP0 + 1])
    else $error("group 1 change did not set its flag");

  a_masked_no_flag: assert property ( // R19
    (pin_change_mask_group1 == 8'h00 && $past(pin_change_mask_group1) == 8'h00
      && !ext_irq_flags[5] && !wr_now) |=> !ext_irq_flags[5])
    else $error("masked group 1 set its flag");

  a_ack_clears: assert property ( // R14
    (irq_ack.grp0 && !grp_hit[0]) |=> !ext_irq_flags[`EPC_BIT_GRP0])
    else $error("acknowledge did not clear group 0 flag");

  a_w1c_clears: assert property ( // R15
    (wr_now && aph.addr == {`EPC_IDX_FLAGS, 2'h0} && wdat[7] && !grp_hit[3])
    |=> !ext_irq_flags[7])
    else $error("write one did not clear group 3 flag");

  a_req_gated: assert property ( // R4
    irq_req.pin |-> $past(cpu_global_ie) && $past(ext_irq_enables[0]))
    else $error("pin request without both enables");

  a_req_follows_flag: assert property ( // R13
    (cpu_global_ie && ext_irq_enables[6] && ext_irq_flags[6]) |=> irq_req.grp2)
    else $error("group 2 flag with enables gave no request");

  a_reserved_zero: assert property ( // R23
    ext_irq_enables[3:1] == 3'h0 && ext_irq_flags[3:1] == 3'h0 &&
    !pin_change_mask_group3[7] && ext_irq_sense_control[7:2] == 6'h00)
    else $error("reserved bit is not zero");

  sequence s_pin_toggle;
    ext_irq_sense_control[1:0] == `EPC_SENSE_ANY && pin_q != pin_prev;
  endsequence

  a_any_sets_flag: assert property (s_pin_toggle |=> ext_irq_flags[`EPC_BIT_PIN]) // R1
    else $error("pin change in any-change mode did not set pin flag");

  a_low_level_req: assert property ( // R5
    (level_mode && cpu_global_ie && ext_irq_enables[`EPC_BIT_PIN] && !pin_q) |=> irq_req.pin)
    else $error("held low level gave no pin request");

  a_grp0_change_flag: assert property ( // R9
    |(chg_diff[7:0] & pin_change_mask_group0) |=> ext_irq_flags[`EPC_BIT_GRP0])
    else $error("group 0 change did not set its flag");

  a_grp2_change_flag: assert property ( // R7
    |(chg_diff[23:16] & pin_change_mask_group2) |=> ext_irq_flags[`EPC_BIT_GRP0 + 2])
    else $error("group 2 change did not set its flag");

  a_grp3_change_flag: assert property ( // R6
    |(chg_diff[30:24] & pin_change_mask_group3[6:0]) |=> ext_irq_flags[`EPC_BIT_GRP0 + 3])
    else $error("group 3 change did not set its flag");

  a_grp_flag_cause: assert property ( // R11
    $rose(ext_irq_flags[`EPC_BIT_GRP0]) |-> $past(grp_hit[0]))
    else $error("group 0 flag rose without an unmasked change");

  a_pin_flag_cause: assert property ( // R12
    $rose(ext_irq_flags[`EPC_BIT_PIN]) |-> $past(pin_edge))
    else $error("pin flag rose without a selected edge");

  a_no_gie_no_req: assert property ( // R13
    !cpu_global_ie |=> irq_req == '0)
    else $error("request raised without global enable");

  a_w1c_zero_keeps: assert property ( // R15
    (wr_now && aph.addr == {`EPC_IDX_FLAGS, 2'h0} && !wdat[4] && !irq_ack.grp0
      && ext_irq_flags[`EPC_BIT_GRP0]) |=> ext_irq_flags[`EPC_BIT_GRP0])
    else $error("writing zero cleared group 0 flag");

  a_mask_gates_grp2: assert property ( // R18
    (pin_change_mask_group2 == 8'h00 && !ext_irq_flags[6] && !wr_now)
    |=> !ext_irq_flags[6])
    else $error("masked group 2 set its flag");

  a_grp_req_gated: assert property ( // R8
    irq_req.grp1 |-> $past(cpu_global_ie) && $past(ext_irq_enables[5]))
    else $error("group 1 request without both enables");

endmodule

// File: epc_cpu_model.sv
// cpu side model: takes the lowest pending vector and enters its routine
module epc_cpu_model
  import epc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ack_on,
  input wire epc_vec_t irq_req,
  output epc_vec_t irq_ack,
  output epc_vec_t seen
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ack <= '0;
      seen <= '0;
    end else begin
      irq_ack <= (ack_on && irq_ack == '0) ? (irq_req & (~irq_req + 5'h01)) : '0;
      seen <= seen | irq_ack;
    end
  end
endmodule

// File: test_epc_irq.sv
// self-checking bench of the pin-change interrupt controller
`include "epc_defines.svh"

module test_epc_irq
  import epc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dpin, gie, ack_on;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [30:0] chg;
  epc_vec_t irq_ack, irq_req, seen;
  int fails, tests_run;

  epc_irq dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .dedicated_ext_irq_pin(dpin), .change_inputs(chg), .cpu_global_ie(gie),
    .irq_ack(irq_ack), .irq_req(irq_req)
  );

  epc_cpu_model cpu (
    .hclk(hclk), .hresetn(hresetn), .ack_on(ack_on), .irq_req(irq_req),
    .irq_ack(irq_ack), .seen(seen)
  );

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check_reg(string name, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_req(string name, epc_vec_t exp);
    tests_run++;
    if (irq_req !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, irq_req);
    end
  endtask

  // single ahb-lite transfer; waits on hready in both phases
  task automatic bus_xfer(logic wr, logic [7:0] idx, logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check_reg("response", 32'h0, {31'h0, hresp});
  endtask

  task automatic reg_wr(logic [7:0] idx, logic [7:0] d);
    logic [31:0] x;
    bus_xfer(1'b1, idx, {24'h0, d}, x);
  endtask

  task automatic reg_chk(string name, logic [7:0] idx, logic [7:0] exp);
    logic [31:0] x;
    bus_xfer(1'b0, idx, 32'h0, x);
    check_reg(name, {24'h0, exp}, x);
  endtask

  task automatic t_regs();
    logic [7:0] idx [8] = '{`EPC_IDX_FLAGS, `EPC_IDX_ENABLES, `EPC_IDX_SENSE,
      `EPC_IDX_MASK0, `EPC_IDX_MASK1, `EPC_IDX_MASK2, `EPC_IDX_MASK3, 8'h10};
    logic [7:0] wm [8] = '{8'h00, 8'hF1, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h00};
    foreach (idx[i]) begin
      reg_chk("reset value", idx[i], 8'h00);
      reg_wr(idx[i], 8'hFF);
      reg_chk("written value", idx[i], wm[i]);
      reg_wr(idx[i], 8'h00);
    end
  endtask

  task automatic t_level();
    gie <= 1'b1;
    reg_wr(`EPC_IDX_ENABLES, 8'h01);
    @(posedge hclk);
    // source holds the pin low through the request and global gate checks
    dpin <= 1'b0;
    repeat (4) @(posedge hclk);
    #1;
    check_req("low level request", 5'h01);
    reg_chk("low level flag", `EPC_IDX_FLAGS, 8'h00);
    gie <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    check_req("global gate", 5'h00);
    @(posedge hclk);
    gie <= 1'b1;
    dpin <= 1'b1;
    repeat (3) @(posedge hclk);
    #1;
    check_req("level released", 5'h00);
  endtask

  task automatic t_edge();
    logic [1:0] s;
    logic v;
    logic exp;
    for (int k = 1; k < 4; k++) begin
      s = k[1:0];
      reg_wr(`EPC_IDX_SENSE, {6'h0, s});
      for (int e = 0; e < 2; e++) begin
        v = e[0];
        @(posedge hclk);
        dpin <= v;
        repeat (5) @(posedge hclk);
        #1;
        exp = (s == `EPC_SENSE_ANY) || (s == (v ? `EPC_SENSE_RISE : `EPC_SENSE_FALL));
        check_req("pin request", {4'h0, exp});
        reg_chk("pin flag", `EPC_IDX_FLAGS, {7'h0, exp});
        reg_wr(`EPC_IDX_FLAGS, 8'h00);
        reg_chk("flag kept", `EPC_IDX_FLAGS, {7'h0, exp});
        reg_wr(`EPC_IDX_FLAGS, 8'h01);
        reg_chk("flag cleared", `EPC_IDX_FLAGS, 8'h00);
      end
    end
    // low pulse of two clocks, caught by its rising edge
    @(posedge hclk);
    dpin <= 1'b0;
    repeat (2) @(posedge hclk);
    dpin <= 1'b1;
    repeat (5) @(posedge hclk);
    #1;
    check_req("short pulse", 5'h01);
    reg_wr(`EPC_IDX_FLAGS, 8'h01);
    reg_chk("pulse flag cleared", `EPC_IDX_FLAGS, 8'h00);
  endtask

  task automatic t_group();
    logic [7:0] midx [4] = '{`EPC_IDX_MASK0, `EPC_IDX_MASK1, `EPC_IDX_MASK2, `EPC_IDX_MASK3};
    logic [4:0] exp = 5'h00;
    ack_on <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      reg_wr(midx[g], 8'h01);
      reg_wr(`EPC_IDX_ENABLES, 8'h10 << g);
      @(posedge hclk);
      chg <= chg ^ (31'h2 << (g * 8));
      repeat (8) @(posedge hclk);
      check_reg("masked input", {27'h0, exp}, {27'h0, seen});
      @(posedge hclk);
      chg <= chg ^ (31'h1 << (g * 8));
      repeat (8) @(posedge hclk);
      exp = exp | (5'h02 << g);
      check_reg("group vector", {27'h0, exp}, {27'h0, seen});
      reg_chk("flag after entry", `EPC_IDX_FLAGS, 8'h00);
    end
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    dpin = 1'b1;
    chg = 31'h0;
    gie = 1'b0;
    ack_on = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_level();
    t_edge();
    t_group();
    finish_test();
  end

  initial begin
    #1ms;
    fails++;
    finish_test();
  end
endmodule
